// ### rce_defines.vh
// constants of the record channel id encoder
`ifndef RCE_DEFINES_VH
`define RCE_DEFINES_VH

// auto id byte field positions
`define RCE_AB_ACTIVE   7
`define RCE_AB_EVENT    6
`define RCE_AB_UNIT     5
`define RCE_AB_SWITCH   4
`define RCE_AB_STAGE_HI 3
`define RCE_AB_PATH_HI  1

// analog line layout
`define RCE_RUNIN_PAT   16'haaaa
`define RCE_RUNIN_BITS  6'h10
`define RCE_BODY_BITS   6'h24
`define RCE_TYPE_AUTO   3'h0
`define RCE_TYPE_RPT    3'h1
`define RCE_TYPE_DET01  3'h2
`define RCE_TYPE_DET23  3'h3
`define RCE_TYPE_USR03  3'h4
`define RCE_TYPE_USR47  3'h5

// digital line layout
`define RCE_INFO_OFFSET 8'h50
`define RCE_IDX_AUTO    6'h02
`define RCE_IDX_END     6'h2a
`define RCE_ACTIVE_LUMA 11'h2d0

`endif

// ### rce_pair_buffer.v
// two-entry valid/ready buffer for the digital id samples
`timescale 1ns/1ps
`default_nettype none
module rce_pair_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] head;
  reg [WIDTH-1:0] tail;
  reg [1:0]       fill;
  wire            push;
  wire            pop;

  assign in_ready_o  = (fill != 2'h2);
  assign out_valid_o = (fill != 2'h0);
  assign out_data_o  = head;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      head <= {WIDTH{1'b0}};
      tail <= {WIDTH{1'b0}};
      fill <= 2'h0;
    end
    else
    begin
      if (pop)
      begin
        head <= (fill == 2'h2) ? tail : in_data_i;
      end
      else if (push && fill == 2'h0)
      begin
        head <= in_data_i;
      end
      if (push && ((fill == 2'h1 && !pop) || (fill == 2'h2)))
      begin
        tail <= in_data_i;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // rce_pair_buffer
`default_nettype wire

// ### rce_bit_shifter.v
// serialises one analog id line, msb first, each bit held for a pixel count
`timescale 1ns/1ps
`default_nettype none
module rce_bit_shifter #(
  parameter WORD_W = 52
) (
  input  wire              clock_i,
  input  wire              rst_n_i,
  input  wire              start_i,
  input  wire [WORD_W-1:0] word_i,
  input  wire [5:0]        nbits_i,
  input  wire [7:0]        pixels_per_bit_i,
  output wire              bit_o,
  output wire              active_o
);
  reg [WORD_W-1:0] shift;
  reg [5:0]        left;
  reg [7:0]        pix;

  assign bit_o    = shift[WORD_W-1];
  assign active_o = (left != 6'h0);

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shift <= {WORD_W{1'b0}};
      left  <= 6'h0;
      pix   <= 8'h0;
    end
    else if (start_i)
    begin
      shift <= word_i;
      left  <= nbits_i;
      pix   <= 8'h0;
    end
    else if (left != 6'h0)
    begin
      // zero pixels per bit is treated as one, so a line always ends
      if (pix + 8'h1 >= pixels_per_bit_i)
      begin
        pix   <= 8'h0;
        left  <= left - 6'h1;
        shift <= {shift[WORD_W-2:0], 1'b0};
      end
      else
      begin
        pix <= pix + 8'h1;
      end
    end
  end
endmodule // rce_bit_shifter
`default_nettype wire

// ### rce_encoder.v
// record channel id encoder: analog and digital id lines in vertical blanking
`timescale 1ns/1ps
`default_nettype none
`include "rce_defines.vh"
module rce_encoder (
  input  wire        clock_i,
  input  wire        rst_n_i,
  // video timing, same clock
  input  wire        field_start_i,
  input  wire        line_start_i,
  // auto id sources, region r in bit r / bits 2r+1:2r
  input  wire [3:0]  region_active_i,
  input  wire [3:0]  new_event_i,
  input  wire        sequence_unit_flag_i,
  input  wire [3:0]  analog_switch_flag_i,
  input  wire [7:0]  cascade_stage_i,
  input  wire [7:0]  input_path_number_i,
  // detector flags of the four local channels
  input  wire [3:0]  video_loss_flag_i,
  input  wire [3:0]  motion_flag_i,
  input  wire [3:0]  blind_flag_i,
  input  wire [3:0]  night_flag_i,
  input  wire [1:0]  link_position_i,
  input  wire [63:0] cascade_detect_i,
  input  wire        nonrealtime_detect_format_i,
  input  wire        analog_switch_select_i,
  // user bytes, byte 0 in bits 63:56
  input  wire [63:0] user_id_i,
  // configuration
  input  wire        analog_auto_id_enable_i,
  input  wire        auto_id_repeat_enable_i,
  input  wire        analog_detect_id_enable_i,
  input  wire        analog_user_id_enable_i,
  input  wire        run_in_enable_i,
  input  wire        digital_id_enable_i,
  input  wire [7:0]  id_vertical_start_i,
  input  wire [7:0]  id_horizontal_start_i,
  input  wire [7:0]  pixels_per_bit_i,
  input  wire [7:0]  one_bit_level_i,
  input  wire [7:0]  zero_bit_level_i,
  // analog id waveform
  output reg  [7:0]  analog_level_o,
  output reg         analog_active_o,
  // digital id luma samples
  output wire [7:0]  id_luma_o,
  output wire        id_luma_valid_o,
  input  wire        id_luma_ready_i
);
  // ******************************
  // line plan states
  // ******************************
  localparam [2:0] LN_IDLE = 3'b001;
  localparam [2:0] LN_DIG  = 3'b010;
  localparam [2:0] LN_ANA  = 3'b100;

  reg  [2:0]   line_state;
  reg  [2:0]   next_line_state;
  reg  [9:0]   line_num;
  reg  [10:0]  hpos;
  reg  [3:0]   event_hold;
  reg  [15:0]  nrt_a;
  reg  [15:0]  nrt_b;
  reg  [51:0]  ana_word;
  reg  [5:0]   ana_len;
  reg          ana_armed;
  reg  [5:0]   dig_idx;
  reg  [10:0]  dig_cnt;
  reg  [31:0]  auto_bytes;
  reg  [63:0]  det_bytes;
  reg  [5:0]   type_en;
  reg  [2:0]   ana_type;
  reg          ana_hit;
  reg  [31:0]  body_bytes;
  reg  [7:0]   dig_sample;
  reg  [3:0]   info_nib;
  integer      r;
  integer      rd;
  integer      rt;
  integer      k;
  wire [9:0]   cur_line;
  wire [9:0]   rel_line;
  wire [9:0]   ana_slot;
  wire [15:0]  local_det;
  wire [159:0] info_all;
  wire [34:0]  body;
  wire         parity;
  wire         sh_bit;
  wire         sh_active;
  wire         sh_start;
  wire         dig_push;
  wire         buf_ready;

  // ******************************
  // field sources
  // ******************************
  // auto bytes, region 0 (left top) leaves first
  always @*
  begin
    auto_bytes = 32'h0;
    for (r = 0; r < 4; r = r + 1)
    begin
      auto_bytes[31-8*r-(7-`RCE_AB_ACTIVE)] = region_active_i[r];
      auto_bytes[31-8*r-(7-`RCE_AB_EVENT)]  = event_hold[r];
      auto_bytes[31-8*r-(7-`RCE_AB_UNIT)]   = sequence_unit_flag_i;
      auto_bytes[31-8*r-(7-`RCE_AB_SWITCH)] = analog_switch_flag_i[r];
      auto_bytes[31-8*r-(7-`RCE_AB_STAGE_HI)-:2] = cascade_stage_i[2*r+:2];
      auto_bytes[31-8*r-(7-`RCE_AB_PATH_HI)-:2]  = input_path_number_i[2*r+:2];
    end
  end

  // one nibble per channel, channel 0 in the high nibble of byte 0
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_nib
      assign local_det[15-4*g-:4] = {video_loss_flag_i[g], motion_flag_i[g],
                                     blind_flag_i[g], night_flag_i[g]};
    end
  endgenerate

  // own stage overrides its slot in the chain image, position 0 leads
  always @*
  begin
    det_bytes = cascade_detect_i;
    for (rd = 0; rd < 4; rd = rd + 1)
    begin
      if (link_position_i == rd[1:0])
      begin
        det_bytes[63-16*rd-:16] = local_det;
      end
    end
    if (nonrealtime_detect_format_i)
    begin
      det_bytes = {nrt_a, nrt_b, 32'h0};
    end
  end

  // event is sticky for a field; a new event in the clearing cycle survives
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      event_hold <= 4'h0;
      nrt_a      <= 16'h0;
      nrt_b      <= 16'h0;
    end
    else
    begin
      event_hold <= (event_hold & {4{~field_start_i}}) | new_event_i;
      // the switch shows which input the detectors are looking at now
      if (analog_switch_select_i)
      begin
        nrt_b <= local_det;
      end
      else
      begin
        nrt_a <= local_det;
      end
    end
  end

  // ******************************
  // line counting and plan
  // ******************************
  assign cur_line = field_start_i ? 10'h0 : line_num + 10'h1;
  assign rel_line = cur_line - {2'h0, id_vertical_start_i};
  assign ana_slot = rel_line - {9'h0, digital_id_enable_i};

  // enabled analog lines in fixed order; at most six of them
  always @*
  begin
    type_en[0] = analog_auto_id_enable_i;
    type_en[1] = analog_auto_id_enable_i & auto_id_repeat_enable_i;
    type_en[2] = analog_detect_id_enable_i;
    // non-realtime detection fits one line, otherwise two are always sent
    type_en[3] = analog_detect_id_enable_i & ~nonrealtime_detect_format_i;
    type_en[4] = analog_user_id_enable_i;
    type_en[5] = analog_user_id_enable_i;
    ana_type = `RCE_TYPE_AUTO;
    ana_hit  = 1'b0;
    k = 0;
    for (rt = 0; rt < 6; rt = rt + 1)
    begin
      if (type_en[rt])
      begin
        if (ana_slot == k[9:0] && !ana_hit)
        begin
          ana_type = rt[2:0];
          ana_hit  = 1'b1;
        end
        k = k + 1;
      end
    end
    if (rel_line[9])
    begin
      ana_hit = 1'b0;
    end
  end

  always @*
  begin
    case (ana_type)
      `RCE_TYPE_DET01: body_bytes = det_bytes[63:32];
      `RCE_TYPE_DET23: body_bytes = det_bytes[31:0];
      `RCE_TYPE_USR03: body_bytes = user_id_i[63:32];
      `RCE_TYPE_USR47: body_bytes = user_id_i[31:0];
      default:         body_bytes = auto_bytes;
    endcase
  end

  assign body   = {body_bytes, ana_type};
  assign parity = ^body;

  always @*
  begin
    next_line_state = LN_IDLE;
    if (digital_id_enable_i && rel_line == 10'h0)
    begin
      next_line_state = LN_DIG;
    end
    else if (ana_hit)
    begin
      next_line_state = LN_ANA;
    end
  end

  // ******************************
  // line sequencer
  // ******************************
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_state <= LN_IDLE;
      line_num   <= 10'h0;
      hpos       <= 11'h0;
      ana_word   <= 52'h0;
      ana_len    <= 6'h0;
      ana_armed  <= 1'b0;
    end
    else if (line_start_i || field_start_i)
    begin
      line_num   <= cur_line;
      hpos       <= 11'h0;
      line_state <= next_line_state;
      ana_armed  <= (next_line_state == LN_ANA);
      if (run_in_enable_i)
      begin
        ana_word <= {`RCE_RUNIN_PAT, body, parity};
        ana_len  <= `RCE_RUNIN_BITS + `RCE_BODY_BITS;
      end
      else
      begin
        ana_word <= {body, parity, 16'h0};
        ana_len  <= `RCE_BODY_BITS;
      end
    end
    else
    begin
      if (hpos != 11'h7ff)
      begin
        hpos <= hpos + 11'h1;
      end
      if (sh_start)
      begin
        ana_armed <= 1'b0;
      end
      case (line_state)
        LN_IDLE: line_state <= LN_IDLE;
        LN_DIG:  line_state <= LN_DIG;
        LN_ANA:  line_state <= LN_ANA;
        default: line_state <= LN_IDLE;
      endcase
    end
  end

  // ******************************
  // analog waveform
  // ******************************
  // horizontal start counts in pairs of pixels
  assign sh_start = ana_armed && !line_start_i && !field_start_i &&
                    (hpos == {2'h0, id_horizontal_start_i, 1'b0});

  rce_bit_shifter #(
    .WORD_W (52)
  ) u_shifter (
    .clock_i          (clock_i),
    .rst_n_i          (rst_n_i),
    .start_i          (sh_start),
    .word_i           (ana_word),
    .nbits_i          (ana_len),
    .pixels_per_bit_i (pixels_per_bit_i),
    .bit_o            (sh_bit),
    .active_o         (sh_active)
  );

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      analog_level_o  <= 8'h0;
      analog_active_o <= 1'b0;
    end
    else
    begin
      analog_active_o <= sh_active;
      analog_level_o  <= !sh_active ? 8'h0 :
                         (sh_bit ? one_bit_level_i : zero_bit_level_i);
    end
  end

  // ******************************
  // digital id line
  // ******************************
  // auto, detection and user bytes laid end to end, high nibble first
  assign info_all = {auto_bytes, det_bytes, user_id_i};

  always @*
  begin
    info_nib = info_all[159-4*(dig_idx-`RCE_IDX_AUTO)-:4];
    // code entries carry their index; info entries carry their nibble plus the offset
    if (dig_idx < `RCE_IDX_AUTO || dig_idx >= `RCE_IDX_END)
    begin
      dig_sample = {2'h0, dig_idx};
    end
    else
    begin
      dig_sample = `RCE_INFO_OFFSET + {4'h0, info_nib};
    end
  end

  // the sequence wraps over the whole active line: 720 / 64 gives 11 whole copies and 16 samples;
  // a stalled receiver shortens the line, words already taken are kept
  assign dig_push = (line_state == LN_DIG) && (dig_cnt != `RCE_ACTIVE_LUMA) &&
                    !line_start_i && !field_start_i;

  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dig_idx <= 6'h0;
      dig_cnt <= 11'h0;
    end
    else if (line_start_i || field_start_i)
    begin
      dig_idx <= 6'h0;
      dig_cnt <= 11'h0;
    end
    else if (dig_push && buf_ready)
    begin
      dig_idx <= dig_idx + 6'h1;
      dig_cnt <= dig_cnt + 11'h1;
    end
  end

  rce_pair_buffer #(
    .WIDTH (8)
  ) u_buffer (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (dig_push),
    .in_ready_o  (buf_ready),
    .in_data_i   (dig_sample),
    .out_valid_o (id_luma_valid_o),
    .out_ready_i (id_luma_ready_i),
    .out_data_o  (id_luma_o)
  );
endmodule // rce_encoder
`default_nettype wire

// ### rce_encoder_properties.sv
// concurrent checks on the ports of the record channel id encoder
`timescale 1ns/1ps
`default_nettype none
module rce_encoder_properties (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       line_start_i,
  input wire logic       field_start_i,
  input wire logic       analog_auto_id_enable_i,
  input wire logic       analog_detect_id_enable_i,
  input wire logic       analog_user_id_enable_i,
  input wire logic       run_in_enable_i,
  input wire logic       digital_id_enable_i,
  input wire logic [7:0] pixels_per_bit_i,
  input wire logic [7:0] one_bit_level_i,
  input wire logic [7:0] zero_bit_level_i,
  input wire logic [7:0] analog_level_o,
  input wire logic       analog_active_o,
  input wire logic [7:0] id_luma_o,
  input wire logic       id_luma_valid_o,
  input wire logic       id_luma_ready_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] run_len;
  // ********
  // waveform length and output checks
  // ********
  always @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      run_len <= 16'h0000;
    else
      run_len <= analog_active_o ? run_len + 16'h0001 : 16'h0000;
  a_idle_level_zero: assert property (!analog_active_o |-> analog_level_o == 8'h00)
    else $error("analog level not zero while idle");
  a_level_choice: assert property (analog_active_o |->
    (analog_level_o == one_bit_level_i || analog_level_o == zero_bit_level_i))
    else $error("analog level is neither bit level");
  a_line_length: assert property ($fell(analog_active_o) |-> run_len ==
    (run_in_enable_i ? 16'h0034 : 16'h0024) *
    {8'h00, (pixels_per_bit_i == 8'h00) ? 8'h01 : pixels_per_bit_i})
    else $error("analog line length wrong");
  a_needs_enable: assert property ($rose(analog_active_o) |->
    analog_auto_id_enable_i || analog_detect_id_enable_i || analog_user_id_enable_i)
    else $error("analog line without enable");
  a_stall_holds: assert property (id_luma_valid_o && !id_luma_ready_i |=>
    id_luma_valid_o && $stable(id_luma_o))
    else $error("luma sample lost under stall");
  a_first_sample: assert property ($rose(id_luma_valid_o) |-> id_luma_o == 8'h00 &&
    $past(digital_id_enable_i, 2) && ($past(line_start_i, 2) || $past(field_start_i, 2)))
    else $error("digital line start wrong");
  a_luma_code: assert property (id_luma_valid_o |->
    id_luma_o < 8'h40 || id_luma_o[7:4] == 4'h5)
    else $error("luma sample outside index or info codes");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |->
    !analog_active_o && analog_level_o == 8'h00 && !id_luma_valid_o)
    else $error("outputs active in reset");
  c_analog_shown: cover property ($rose(analog_active_o));
  c_stall: cover property (id_luma_valid_o && !id_luma_ready_i);
  c_digital_done: cover property ($fell(id_luma_valid_o));
endmodule // rce_encoder_properties
bind rce_encoder rce_encoder_properties rce_encoder_properties_inst (.*);
`default_nettype wire

// ### rce_stream_sink.sv
// downstream sink taking the digital id luma samples by valid/ready
`timescale 1ns/1ps
`default_nettype none
module rce_stream_sink (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       slow_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output var  logic       ready_o
);
  logic [1:0] ph;
  logic [7:0] rx[$];
  // ********
  // acceptance
  // ********
  // slow mode takes one cycle in four, so the two-entry buffer fills and refuses
  always @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      ph <= 2'h0;
      ready_o <= 1'b0;
    end
    else
    begin
      ph <= ph + 2'h1;
      ready_o <= !slow_i || ph == 2'h2;
    end
  always @(posedge clock_i)
    if (valid_i && ready_o)
      rx.push_back(data_i);
endmodule // rce_stream_sink
`default_nettype wire

// ### rce_encoder_test.sv
// self-checking bench of the record channel id encoder
`timescale 1ns/1ps
`default_nettype none
module rce_encoder_test;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t mismatch", $time); end end
  localparam int LINE = 780;
  logic        clock_i, rst_n_i, field_start_i, line_start_i, sequence_unit_flag_i, slow;
  logic [3:0]  region_active_i, new_event_i, analog_switch_flag_i, evm;
  logic [3:0]  video_loss_flag_i, motion_flag_i, blind_flag_i, night_flag_i;
  logic [7:0]  cascade_stage_i, input_path_number_i, id_vertical_start_i, id_horizontal_start_i;
  logic [7:0]  pixels_per_bit_i, one_bit_level_i, zero_bit_level_i, analog_level_o, id_luma_o;
  logic [1:0]  link_position_i;
  logic [63:0] cascade_detect_i, user_id_i;
  logic        nonrealtime_detect_format_i, analog_switch_select_i, analog_auto_id_enable_i;
  logic        auto_id_repeat_enable_i, analog_detect_id_enable_i, analog_user_id_enable_i;
  logic        run_in_enable_i, digital_id_enable_i, analog_active_o, id_luma_valid_o;
  logic        id_luma_ready_i;
  logic [15:0] na;
  logic [51:0] got;
  int          fails, n_checks, nb, nl, cyc;
  int          tq[$];
  // columns: digital auto repeat detect user run-in nonrealtime, position, analog lines
  logic [12:0] rows [4] = '{13'h1b85, 13'h1f26, 13'h0ef3, 13'h1192};
  rce_encoder rce_encoder_inst (.*);
  rce_stream_sink rce_stream_sink_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .valid_i(id_luma_valid_o), .data_i(id_luma_o), .ready_o(id_luma_ready_i));
  // ********
  // expected values
  // ********
  function automatic logic [15:0] nib16(input logic [3:0] l, m, b, n);
    for (int c = 0; c < 4; c++)
      nib16 = {nib16[11:0], l[c], m[c], b[c], n[c]};
  endfunction
  function automatic logic [31:0] ab();
    for (int r = 0; r < 4; r++)
      ab = {ab[23:0], region_active_i[r], evm[r], sequence_unit_flag_i, analog_switch_flag_i[r],
            cascade_stage_i[2*r+:2], input_path_number_i[2*r+:2]};
  endfunction
  function automatic logic [63:0] dt();
    dt = cascade_detect_i;
    dt[63-16*link_position_i -: 16] = nib16(video_loss_flag_i, motion_flag_i, blind_flag_i,
                                            night_flag_i);
  endfunction
  function automatic logic [51:0] aw(input int t);
    logic [31:0] p;
    logic [34:0] d;
    logic [63:0] x;
    x = dt();
    case (t)
      0, 1: p = ab();
      2: p = nonrealtime_detect_format_i ? {na, x[63-16*link_position_i -: 16]} : x[63:32];
      3: p = x[31:0];
      4: p = user_id_i[63:32];
      default: p = user_id_i[31:0];
    endcase
    d = {p, t[2:0]};
    aw = {run_in_enable_i ? 16'haaaa : 16'h0000, d, ^d};
  endfunction
  function automatic logic [7:0] ds(input int i);
    logic [159:0] f;
    f = {ab(), dt(), user_id_i};
    ds = (i < 2 || i > 41) ? i[7:0] : {4'h5, f[159-4*(i-2) -: 4]};
  endfunction
  // ********
  // stimulus
  // ********
  task automatic setcfg(input logic [8:0] c);
    {digital_id_enable_i, analog_auto_id_enable_i, auto_id_repeat_enable_i,
     analog_detect_id_enable_i, analog_user_id_enable_i, run_in_enable_i,
     nonrealtime_detect_format_i, link_position_i} = c;
  endtask
  task automatic line(input bit fs);
    int ph;
    ph = 0;
    nb = 0;
    got = 52'h0;
    @(posedge clock_i);
    #5 field_start_i = fs;
    line_start_i = !fs;
    @(posedge clock_i);
    #5 field_start_i = 1'b0;
    line_start_i = 1'b0;
    repeat (LINE)
    begin
      @(posedge clock_i);
      #1;
      if (analog_active_o === 1'b1)
      begin
        if (ph == 0)
          got = {got[50:0], analog_level_o === one_bit_level_i};
        nb = nb + (ph == 0);
        ph = (ph + 1) % pixels_per_bit_i;
      end
    end
    #4;
  endtask
  task automatic field(input bit ev, input bit sl);
    int b, b0, k, n, rel;
    slow = sl;
    evm = 4'h0;
    tq = {};
    for (int t = 0; t < 6; t++)
      if ((t == 0 && analog_auto_id_enable_i) || (t == 2 && analog_detect_id_enable_i) ||
          (t == 1 && analog_auto_id_enable_i && auto_id_repeat_enable_i) ||
          (t == 3 && analog_detect_id_enable_i && !nonrealtime_detect_format_i) ||
          (t > 3 && analog_user_id_enable_i))
        tq.push_back(t);
    b0 = rce_stream_sink_inst.rx.size();
    for (int l = 0; l < 8; l++)
    begin
      b = rce_stream_sink_inst.rx.size();
      line(l == 0);
      rel = l - 1;
      k = rel - digital_id_enable_i;
      if (rel >= 0 && k >= 0 && k < tq.size())
      begin
        nl++;
        `CHK(nb, run_in_enable_i ? 52 : 36)
        `CHK(got, aw(tq[k]))
      end
      else
        `CHK(nb, 0)
      n = rce_stream_sink_inst.rx.size() - b;
      if (!sl)
        `CHK(n, (rel == 0 && digital_id_enable_i) ? 720 : 0)
      for (int i = 0; i < n && !sl; i++)
        `CHK(rce_stream_sink_inst.rx[b + i], ds(i % 64))
      if (ev && l == 0)
      begin
        new_event_i = 4'h2;
        evm = 4'h2;
        @(posedge clock_i);
        #5 new_event_i = 4'h0;
      end
    end
    n = rce_stream_sink_inst.rx.size() - b0;
    if (sl)
      `CHK(n > 0 && n < 720, 1'b1)
    for (int i = 0; i < n && sl; i++)
      `CHK(rce_stream_sink_inst.rx[b0 + i], ds(i % 64))
  endtask
  task automatic test_done();
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      fails++;
      test_done();
    end
  end
  initial
  begin
    {rst_n_i, field_start_i, line_start_i, new_event_i, analog_switch_select_i, slow} = 9'h0;
    setcfg(9'h000);
    {region_active_i, analog_switch_flag_i, cascade_stage_i, input_path_number_i} = 24'hb61be4;
    {video_loss_flag_i, motion_flag_i, blind_flag_i, night_flag_i} = 16'h1248;
    {cascade_detect_i, user_id_i} = {64'h0123456789abcdef, 64'hfedcba9876543210};
    {sequence_unit_flag_i, id_vertical_start_i, id_horizontal_start_i} = 17'h10104;
    {pixels_per_bit_i, one_bit_level_i, zero_bit_level_i} = 24'h02c010;
    na = nib16(4'h1, 4'h2, 4'h4, 4'h8);
    repeat (20) @(posedge clock_i);
    #5 rst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #5 {video_loss_flag_i, motion_flag_i, blind_flag_i, night_flag_i} = 16'hc5a3;
    analog_switch_select_i = 1'b1;
    for (int r = 0; r < 4; r++)
    begin
      setcfg(rows[r][12:4]);
      nl = 0;
      field(1'b0, 1'b0);
      `CHK(nl, int'(rows[r][3:0]))
    end
    setcfg(9'h180);
    field(1'b1, 1'b0);
    setcfg(9'h100);
    field(1'b0, 1'b1);
    setcfg(9'h088);
    id_vertical_start_i = 8'h00;
    @(posedge clock_i);
    #5 field_start_i = 1'b1;
    @(posedge clock_i);
    #5 field_start_i = 1'b0;
    repeat (40) @(posedge clock_i);
    #5 `CHK(analog_active_o, 1'b1)
    rst_n_i = 1'b0;
    #1 `CHK({analog_active_o, analog_level_o, id_luma_valid_o}, 10'h000)
    repeat (20) @(posedge clock_i);
    #5 rst_n_i = 1'b1;
    id_vertical_start_i = 8'h01;
    field(1'b0, 1'b0);
    test_done();
  end
endmodule // rce_encoder_test
`default_nettype wire
